// ==== core/peiu_event_irq.sv ====
// Module: event latch, enable mask and interrupt pin of the transceiver
// Behaviour
// (R1) Interrupt only for enabled occurring event
// (R2) Enable mask resets to zero
// (R3) Status bit set if event since read
// (R4) Status latches regardless of enable bit
// (R5) Bit 15 negotiation fault, clear on read
// (R6) Bit 14 rate change, clear on read
// (R7) Bit 13 duplex change, clear on read
// (R8) Bit 12 page received, clear on read
// (R9) Bit 11 negotiation done, clear on read
// (R10) Bit 10 link change, clear on read
// (R11) Bit 8 false carrier, clear on read
// (R12) Bit 6 crossover change, clear on read
// (R13) Bit 5 rate downshift, clear on read
// (R14) Bit 4 sleep change, clear on read
// (R15) Bit 3 wake packet, clear on read
// (R16) Bit 2 MAC interface error, clear on read
// (R17) Bit 1 polarity change, clear on read
// (R18) Bit 0 jabber, clear on read
// (R19) Polarity bit resets 1, 1 is low
// (R20) Bits 9,7 zero; pin held while pending
// (R21) Event during clearing read stays latched
`timescale 1ns/1ps
module peiu_event_irq
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic negotiation_fault_flag,
  input wire logic rate_change_flag,
  input wire logic duplex_change_flag,
  input wire logic page_received_flag,
  input wire logic negotiation_done_flag,
  input wire logic link_change_flag,
  input wire logic false_carrier_flag,
  input wire logic crossover_change_flag,
  input wire logic rate_downshift_flag,
  input wire logic sleep_change_flag,
  input wire logic wake_packet_flag,
  input wire logic mac_interface_error_flag,
  input wire logic polarity_change_flag,
  input wire logic jabber_flag,
  output logic irq_pin
);

  // ****************************************************************
  // Event vector
  // ****************************************************************
  logic [15:0] event_vec;
  logic [15:0] interrupt_enable_mask_q;
  logic [15:0] interrupt_event_status_q;
  logic irq_active_low_q;
  logic status_read;
  logic pending;

  always_comb
  begin
    event_vec = 16'h0000;
    event_vec[peiu_pkg::BIT_NEG_FAULT] = negotiation_fault_flag; // R5
    event_vec[peiu_pkg::BIT_RATE_CHANGE] = rate_change_flag; // R6
    event_vec[peiu_pkg::BIT_DUPLEX_CHANGE] = duplex_change_flag; // R7
    event_vec[peiu_pkg::BIT_PAGE_RX] = page_received_flag; // R8
    event_vec[peiu_pkg::BIT_NEG_DONE] = negotiation_done_flag; // R9
    event_vec[peiu_pkg::BIT_LINK_CHANGE] = link_change_flag; // R10
    event_vec[peiu_pkg::BIT_FALSE_CARRIER] = false_carrier_flag; // R11
    event_vec[peiu_pkg::BIT_CROSSOVER_CHANGE] = crossover_change_flag; // R12
    event_vec[peiu_pkg::BIT_RATE_DOWNSHIFT] = rate_downshift_flag; // R13
    event_vec[peiu_pkg::BIT_SLEEP_CHANGE] = sleep_change_flag; // R14
    event_vec[peiu_pkg::BIT_WAKE_PACKET] = wake_packet_flag; // R15
    event_vec[peiu_pkg::BIT_MAC_IF_ERROR] = mac_interface_error_flag; // R16
    event_vec[peiu_pkg::BIT_POLARITY_CHANGE] = polarity_change_flag; // R17
    event_vec[peiu_pkg::BIT_JABBER] = jabber_flag; // R18
  end

  assign status_read = reg_read &&
    (reg_addr == peiu_pkg::ADDR_EVENT_STATUS);

  // ****************************************************************
  // Enable mask register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
      interrupt_enable_mask_q <= peiu_pkg::RST_ENABLE_MASK; // R2
    else if (reg_write && reg_addr == peiu_pkg::ADDR_ENABLE_MASK)
      interrupt_enable_mask_q <= reg_wdata & peiu_pkg::IMPL_MASK; // R20
  end

  // ****************************************************************
  // Polarity configuration
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
      irq_active_low_q <= peiu_pkg::RST_IRQ_ACTIVE_LOW; // R19
    else if (reg_write && reg_addr == peiu_pkg::ADDR_POLARITY_CFG)
      irq_active_low_q <= reg_wdata[peiu_pkg::BIT_IRQ_ACTIVE_LOW]; // R19
  end

  // ****************************************************************
  // Event status, latch high, clear on read
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
      interrupt_event_status_q <= peiu_pkg::RST_EVENT_STATUS;
    else if (status_read)
      interrupt_event_status_q <= event_vec & peiu_pkg::IMPL_MASK; // R21
    else
      interrupt_event_status_q <= (interrupt_event_status_q | event_vec)
        & peiu_pkg::IMPL_MASK; // R3 R4
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      case (reg_addr)
        peiu_pkg::ADDR_ENABLE_MASK: reg_rdata <= interrupt_enable_mask_q;
        peiu_pkg::ADDR_EVENT_STATUS: reg_rdata <= interrupt_event_status_q;
        peiu_pkg::ADDR_POLARITY_CFG:
        begin
          reg_rdata <= 16'h0000;
          reg_rdata[peiu_pkg::BIT_IRQ_ACTIVE_LOW] <= irq_active_low_q;
        end
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // ****************************************************************
  // Interrupt pin
  // ****************************************************************
  assign pending = |(interrupt_event_status_q & interrupt_enable_mask_q);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      irq_pin <= peiu_pkg::RST_IRQ_ACTIVE_LOW;
    else
      irq_pin <= pending ^ irq_active_low_q; // R1 R20 R19
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_mask_reset: assert property (@(posedge clk) // R2
    $rose(resetn) |-> interrupt_enable_mask_q == 16'h0000)
    else $error("enable mask not zero after reset");

  a_irq_follows: assert property (@(posedge clk) disable iff (!resetn) // R1
    ##1 $past(resetn) |-> irq_pin ==
      ($past(pending) ^ $past(irq_active_low_q)))
    else $error("interrupt pin does not follow pending events");

  a_status_latch: assert property (@(posedge clk) disable iff (!resetn) // R4
    (event_vec[peiu_pkg::BIT_JABBER] && !interrupt_enable_mask_q[0])
      |=> interrupt_event_status_q[peiu_pkg::BIT_JABBER])
    else $error("disabled event not latched");

  a_status_hold: assert property (@(posedge clk) disable iff (!resetn) // R3
    (!status_read && interrupt_event_status_q[peiu_pkg::BIT_NEG_FAULT])
      |=> interrupt_event_status_q[peiu_pkg::BIT_NEG_FAULT])
    else $error("status bit lost without read");

  a_read_clear: assert property (@(posedge clk) disable iff (!resetn) // R5
    (status_read && event_vec == 16'h0000)
      |=> interrupt_event_status_q == 16'h0000 ##0
      reg_rdata == $past(interrupt_event_status_q))
    else $error("clearing read wrong");

  a_race_kept: assert property (@(posedge clk) disable iff (!resetn) // R21
    (status_read && event_vec[peiu_pkg::BIT_LINK_CHANGE])
      |=> interrupt_event_status_q[peiu_pkg::BIT_LINK_CHANGE])
    else $error("event lost during clearing read");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn) // R20
    interrupt_event_status_q[9] == 1'b0 && interrupt_event_status_q[7] == 1'b0
      && interrupt_enable_mask_q[9] == 1'b0
      && interrupt_enable_mask_q[7] == 1'b0)
    else $error("reserved bit set");

  a_pol_reset: assert property (@(posedge clk) // R19
    $rose(resetn) |-> irq_active_low_q && irq_pin)
    else $error("polarity not active low after reset");

  a_status_reset: assert property (@(posedge clk) // R5
    $rose(resetn) |-> interrupt_event_status_q == 16'h0000)
    else $error("status not zero after reset");

  a_mask_write: assert property (@(posedge clk) disable iff (!resetn) // R2
    (reg_write && reg_addr == peiu_pkg::ADDR_ENABLE_MASK)
      |=> interrupt_enable_mask_q == ($past(reg_wdata) & peiu_pkg::IMPL_MASK))
    else $error("enable mask write lost");

  a_rsvd_read: assert property (@(posedge clk) disable iff (!resetn) // R20
    (reg_read && reg_addr == peiu_pkg::ADDR_ENABLE_MASK)
      |=> reg_rdata[9] == 1'b0 && reg_rdata[7] == 1'b0)
    else $error("reserved mask bit read as one");

  a_no_spurious: assert property (@(posedge clk) disable iff (!resetn) // R3
    ##1 ((interrupt_event_status_q & ~$past(interrupt_event_status_q)
      & ~$past(event_vec)) == 16'h0000))
    else $error("status bit set without event");

  // ****************************************************************
  // Per-event latch and clear checks
  // ****************************************************************

  a_fault_set: assert property (@(posedge clk) disable iff (!resetn) // R5
    negotiation_fault_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_NEG_FAULT])
    else $error("fault event not latched");

  a_fault_clr: assert property (@(posedge clk) disable iff (!resetn) // R5
    (status_read && !negotiation_fault_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_NEG_FAULT])
    else $error("fault bit not cleared by read");

  a_rate_set: assert property (@(posedge clk) disable iff (!resetn) // R6
    rate_change_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_RATE_CHANGE])
    else $error("rate change event not latched");

  a_rate_clr: assert property (@(posedge clk) disable iff (!resetn) // R6
    (status_read && !rate_change_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_RATE_CHANGE])
    else $error("rate change bit not cleared by read");

  a_duplex_set: assert property (@(posedge clk) disable iff (!resetn) // R7
    duplex_change_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_DUPLEX_CHANGE])
    else $error("duplex change event not latched");

  a_duplex_clr: assert property (@(posedge clk) disable iff (!resetn) // R7
    (status_read && !duplex_change_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_DUPLEX_CHANGE])
    else $error("duplex change bit not cleared by read");

  a_page_set: assert property (@(posedge clk) disable iff (!resetn) // R8
    page_received_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_PAGE_RX])
    else $error("page event not latched");

  a_page_clr: assert property (@(posedge clk) disable iff (!resetn) // R8
    (status_read && !page_received_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_PAGE_RX])
    else $error("page bit not cleared by read");

  a_done_set: assert property (@(posedge clk) disable iff (!resetn) // R9
    negotiation_done_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_NEG_DONE])
    else $error("negotiation done event not latched");

  a_done_clr: assert property (@(posedge clk) disable iff (!resetn) // R9
    (status_read && !negotiation_done_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_NEG_DONE])
    else $error("negotiation done bit not cleared by read");

  a_link_set: assert property (@(posedge clk) disable iff (!resetn) // R10
    link_change_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_LINK_CHANGE])
    else $error("link change event not latched");

  a_link_clr: assert property (@(posedge clk) disable iff (!resetn) // R10
    (status_read && !link_change_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_LINK_CHANGE])
    else $error("link change bit not cleared by read");

  a_carrier_set: assert property (@(posedge clk) disable iff (!resetn) // R11
    false_carrier_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_FALSE_CARRIER])
    else $error("false carrier event not latched");

  a_carrier_clr: assert property (@(posedge clk) disable iff (!resetn) // R11
    (status_read && !false_carrier_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_FALSE_CARRIER])
    else $error("false carrier bit not cleared by read");

  a_xover_set: assert property (@(posedge clk) disable iff (!resetn) // R12
    crossover_change_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_CROSSOVER_CHANGE])
    else $error("crossover event not latched");

  a_xover_clr: assert property (@(posedge clk) disable iff (!resetn) // R12
    (status_read && !crossover_change_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_CROSSOVER_CHANGE])
    else $error("crossover bit not cleared by read");

  a_shift_set: assert property (@(posedge clk) disable iff (!resetn) // R13
    rate_downshift_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_RATE_DOWNSHIFT])
    else $error("downshift event not latched");

  a_shift_clr: assert property (@(posedge clk) disable iff (!resetn) // R13
    (status_read && !rate_downshift_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_RATE_DOWNSHIFT])
    else $error("downshift bit not cleared by read");

  a_sleep_set: assert property (@(posedge clk) disable iff (!resetn) // R14
    sleep_change_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_SLEEP_CHANGE])
    else $error("sleep change event not latched");

  a_sleep_clr: assert property (@(posedge clk) disable iff (!resetn) // R14
    (status_read && !sleep_change_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_SLEEP_CHANGE])
    else $error("sleep change bit not cleared by read");

  a_wake_set: assert property (@(posedge clk) disable iff (!resetn) // R15
    wake_packet_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_WAKE_PACKET])
    else $error("wake event not latched");

  a_wake_clr: assert property (@(posedge clk) disable iff (!resetn) // R15
    (status_read && !wake_packet_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_WAKE_PACKET])
    else $error("wake bit not cleared by read");

  a_mac_err_set: assert property (@(posedge clk) disable iff (!resetn) // R16
    mac_interface_error_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_MAC_IF_ERROR])
    else $error("mac interface error event not latched");

  a_mac_err_clr: assert property (@(posedge clk) disable iff (!resetn) // R16
    (status_read && !mac_interface_error_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_MAC_IF_ERROR])
    else $error("mac interface error bit not cleared by read");

  a_pol_chg_set: assert property (@(posedge clk) disable iff (!resetn) // R17
    polarity_change_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_POLARITY_CHANGE])
    else $error("polarity change event not latched");

  a_pol_chg_clr: assert property (@(posedge clk) disable iff (!resetn) // R17
    (status_read && !polarity_change_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_POLARITY_CHANGE])
    else $error("polarity change bit not cleared by read");

  a_jabber_set: assert property (@(posedge clk) disable iff (!resetn) // R18
    jabber_flag
      |=> interrupt_event_status_q[peiu_pkg::BIT_JABBER])
    else $error("jabber event not latched");

  a_jabber_clr: assert property (@(posedge clk) disable iff (!resetn) // R18
    (status_read && !jabber_flag)
      |=> !interrupt_event_status_q[peiu_pkg::BIT_JABBER])
    else $error("jabber bit not cleared by read");

endmodule : peiu_event_irq

// ==== core/peiu_pkg.sv ====
// Package: register map, field positions and reset values of the event unit
package peiu_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_ENABLE_MASK = 8'h12;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h13;
  localparam logic [7:0] ADDR_POLARITY_CFG = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_NEG_FAULT = 15;
  localparam int BIT_RATE_CHANGE = 14;
  localparam int BIT_DUPLEX_CHANGE = 13;
  localparam int BIT_PAGE_RX = 12;
  localparam int BIT_NEG_DONE = 11;
  localparam int BIT_LINK_CHANGE = 10;
  localparam int BIT_FALSE_CARRIER = 8;
  localparam int BIT_CROSSOVER_CHANGE = 6;
  localparam int BIT_RATE_DOWNSHIFT = 5;
  localparam int BIT_SLEEP_CHANGE = 4;
  localparam int BIT_WAKE_PACKET = 3;
  localparam int BIT_MAC_IF_ERROR = 2;
  localparam int BIT_POLARITY_CHANGE = 1;
  localparam int BIT_JABBER = 0;
  localparam int BIT_IRQ_ACTIVE_LOW = 13;

  // ****************************************************************
  // Implemented bits and reset values
  // ****************************************************************
  localparam logic [15:0] IMPL_MASK = 16'hFD7F;
  localparam logic [15:0] RST_ENABLE_MASK = 16'h0000;
  localparam logic [15:0] RST_EVENT_STATUS = 16'h0000;
  localparam logic RST_IRQ_ACTIVE_LOW = 1'b1;

endpackage : peiu_pkg

// ==== tb/peiu_host_model.sv ====
// Host side model that turns the interrupt pin into a pending level
`timescale 1ns/1ps
module peiu_host_model
(
  input wire logic irq_pin,
  input wire logic active_low,
  output logic irq_active
);
  assign irq_active = irq_pin ^ active_low;
endmodule : peiu_host_model

// ==== tb/testbench.sv ====
// Testbench: register, event latch and interrupt pin traffic
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] MA = peiu_pkg::ADDR_ENABLE_MASK;
  localparam logic [7:0] ST = peiu_pkg::ADDR_EVENT_STATUS;
  localparam logic [7:0] PC = peiu_pkg::ADDR_POLARITY_CFG;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic [15:0] reg_rdata;
  logic [15:0] ev = 16'h0;
  logic irq_pin;
  logic irq_active;
  logic low_cfg = 1'h1;
  logic [15:0] mk;
  logic [15:0] d;
  logic [31:0] seed = 32'h00007786;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  peiu_event_irq u_peiu_event_irq
  (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq_pin(irq_pin),
    .negotiation_fault_flag(ev[15]), .rate_change_flag(ev[14]),
    .duplex_change_flag(ev[13]), .page_received_flag(ev[12]),
    .negotiation_done_flag(ev[11]), .link_change_flag(ev[10]),
    .false_carrier_flag(ev[8]), .crossover_change_flag(ev[6]),
    .rate_downshift_flag(ev[5]), .sleep_change_flag(ev[4]),
    .wake_packet_flag(ev[3]), .mac_interface_error_flag(ev[2]),
    .polarity_change_flag(ev[1]), .jabber_flag(ev[0])
  );
  peiu_host_model u_peiu_host_model
  (
    .irq_pin(irq_pin), .active_low(low_cfg), .irq_active(irq_active)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic pend(input logic [15:0] st, input logic [15:0] m);
    return |(st & m & peiu_pkg::IMPL_MASK);
  endfunction : pend
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'h1;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] evs);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    ev <= evs;
    @(posedge clk);
    reg_read <= 1'h0;
    ev <= 16'h0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask : rd
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 16'h0;
    @(posedge clk);
    @(negedge clk);
  endtask : pulse
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    @(negedge clk);
    chk({15'h0, irq_pin}, 16'h1);
    rd(MA, 16'h0, 16'h0);
    rd(PC, 16'h2000, 16'h0);
    rd(8'h20, 16'h0, 16'h0);
    for (int b = 0; b < 16; b++)
    begin
      d = (16'h1 << b) & peiu_pkg::IMPL_MASK;
      pulse(16'h1 << b);
      chk({15'h0, irq_active}, 16'h0);
      rd(ST, d, 16'h0);
      rd(ST, 16'h0, 16'h0);
    end
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      mk = (i < 2) ? 16'hFFFF : seed[15:0];
      wr(MA, mk);
      rd(MA, mk & peiu_pkg::IMPL_MASK, 16'h0);
      seed = xs(seed);
      d = (i == 1) ? 16'hFFFF : seed[15:0];
      pulse(d);
      chk({15'h0, irq_active}, {15'h0, pend(d, mk)});
      rd(ST, d & peiu_pkg::IMPL_MASK, seed[31:16]);
      rd(ST, seed[31:16] & peiu_pkg::IMPL_MASK, 16'h0);
    end
    wr(PC, 16'h0);
    low_cfg <= 1'h0;
    rd(PC, 16'h0, 16'h0);
    wr(MA, 16'hFFFF);
    pulse(16'h1);
    chk({15'h0, irq_pin}, 16'h1);
    rd(ST, 16'h1, 16'h0);
    pulse(16'h8000);
    wr(ST, 16'h0000);
    rd(ST, 16'h8000, 16'h0);
    pulse(16'h0400);
    @(posedge clk);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    low_cfg <= 1'h1;
    @(negedge clk);
    chk({15'h0, irq_pin}, 16'h1);
    rd(MA, 16'h0, 16'h0);
    rd(PC, 16'h2000, 16'h0);
    rd(ST, 16'h0, 16'h0);
    stop_test();
  end
endmodule : testbench
